/* File: core/acsr_pkg.sv */
// Shared constants and types for the sample status register group
package acsr_pkg;

    // Register byte addresses on the serial register port
    localparam logic [6:0] ADDR_STATUS    = 7'h00;
    localparam logic [6:0] ADDR_X_HIGH    = 7'h01;
    localparam logic [6:0] ADDR_X_LOW     = 7'h02;
    localparam logic [6:0] ADDR_Y_HIGH    = 7'h03;
    localparam logic [6:0] ADDR_Y_LOW     = 7'h04;
    localparam logic [6:0] ADDR_Z_HIGH    = 7'h05;
    localparam logic [6:0] ADDR_Z_LOW     = 7'h06;
    localparam logic [6:0] ADDR_MODE      = 7'h0b;
    localparam logic [6:0] ADDR_ORIGIN    = 7'h0c;
    localparam logic [6:0] ADDR_ORIENT    = 7'h10;
    localparam logic [6:0] ADDR_MOTION    = 7'h16;
    localparam logic [6:0] ADDR_TRANSIENT = 7'h1e;
    localparam logic [6:0] ADDR_PULSE     = 7'h22;
    localparam logic [6:0] ADDR_RESET     = 7'h00;

    // Status byte field positions
    localparam int BIT_ALL_OW = 7;
    localparam int BIT_Z_OW   = 6;
    localparam int BIT_Y_OW   = 5;
    localparam int BIT_X_OW   = 4;
    localparam int BIT_ALL_DR = 3;
    localparam int BIT_Z_DR   = 2;
    localparam int BIT_Y_DR   = 1;
    localparam int BIT_X_DR   = 0;

    // Interrupt origin byte field positions
    localparam int BIT_ORG_SLEEP  = 7;
    localparam int BIT_ORG_TRANS  = 5;
    localparam int BIT_ORG_ORIENT = 4;
    localparam int BIT_ORG_PULSE  = 3;
    localparam int BIT_ORG_MOTION = 2;
    localparam int BIT_ORG_DRDY   = 0;

    // Axis indices and sample layout
    localparam int AXIS_X      = 0;
    localparam int AXIS_Y      = 1;
    localparam int AXIS_Z      = 2;
    localparam int NUM_AXES    = 3;
    localparam int SAMPLE_W    = 10;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [5:0] LOW_PAD     = 6'h00;
    localparam logic [5:0] MODE_PAD    = 6'h00;
    localparam logic [7:0] ORIGIN_RST  = 8'h00;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_WAKE    = 2'b01,
        MODE_SLEEP   = 2'b10
    } acsr_mode_e;

    typedef enum logic [1:0] {
        OP_ADDR = 2'b00,
        OP_READ = 2'b01,
        OP_STOP = 2'b10
    } acsr_op_e;

    // Link side request handshake states, one bit changing per step from idle to done
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_WAIT = 2'b01,
        LK_DONE = 2'b11
    } acsr_lnk_e;

    typedef struct packed {
        acsr_op_e   op;
        logic [6:0] addr;
    } acsr_req_s;

    typedef struct packed {
        logic [NUM_AXES-1:0][SAMPLE_W-1:0] axis;
    } acsr_sample_s;

    typedef struct packed {
        logic sleep;
        logic trans;
        logic orient;
        logic pulse;
        logic motion;
    } acsr_fn_s;

endpackage

/* File: core/acsr_sync2.sv */
// Two-flop level synchroniser with clock enable
`timescale 1ns/1ns
`default_nettype none
module acsr_sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic d,
    output var  logic q
);
    logic meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            q       <= 1'b0;
        end else if (en) begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

/* File: core/acsr_core.sv */
// Sample status, axis data, mode and interrupt origin registers behind a link-clocked read port
`timescale 1ns/1ns
`default_nettype none
module acsr_core
    import acsr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         smp_valid,
    input  wire acsr_sample_s smp,
    input  wire logic [2:0]   smp_axes,
    input  wire logic [2:0]   axis_en,
    input  wire logic [1:0]   op_mode,
    input  wire logic         fast_read,
    input  wire logic         drdy_int_en,
    input  wire acsr_fn_s     fn_irq,
    input  wire logic         link_clk,
    input  wire logic         lk_req_valid,
    input  wire acsr_req_s    lk_req,
    output var  logic         lk_req_ready,
    output var  logic         lk_rsp_valid,
    output var  logic [7:0]   lk_rsp_data
);

    // Next burst address; low bytes skipped in fast mode
    function automatic logic [6:0] next_addr(input logic [6:0] a, input logic fast);
        logic [6:0] n;
        n = a + 7'h01;
        if (a == ADDR_STATUS) begin
            n = ADDR_X_HIGH;
        end else if (fast && (a == ADDR_X_HIGH)) begin
            n = ADDR_Y_HIGH;
        end else if (fast && (a == ADDR_Y_HIGH)) begin
            n = ADDR_Z_HIGH;
        end else if (fast && (a == ADDR_Z_HIGH)) begin
            n = ADDR_STATUS;
        end else if (a == ADDR_Z_LOW) begin
            n = ADDR_STATUS;
        end
        return n;
    endfunction

    // High byte address of an axis
    function automatic logic [6:0] high_addr(input int i);
        logic [6:0] a;
        a = ADDR_X_HIGH;
        if (i == AXIS_Y) begin
            a = ADDR_Y_HIGH;
        end else if (i == AXIS_Z) begin
            a = ADDR_Z_HIGH;
        end
        return a;
    endfunction

    // Sample bits nine to two fill the high byte
    function automatic logic [7:0] high_byte(input logic [SAMPLE_W-1:0] v);
        return v[SAMPLE_W-1:2];
    endfunction

    // Latched two bits on top, the rest reads zero
    function automatic logic [7:0] low_byte(input logic [1:0] l);
        return {l, LOW_PAD};
    endfunction

    // Rising edge from the level and its value one edge earlier
    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // Link domain: takes one request, hands it over by toggle, waits.
    // Only one request is in flight, so the held request and the answer
    // byte stay put while their toggle crosses; ce low stalls the answer
    acsr_lnk_e   lk_state_ff;
    acsr_req_s   lk_hold_ff;
    logic        req_tgl_ff;
    logic        ack_lk_sync;
    logic        lk_rsp_valid_ff;
    logic [7:0]  lk_rsp_data_ff;
    logic        ack_tgl_ff;
    logic [7:0]  rsp_byte_ff;

    wire         lk_take  = (lk_state_ff == LK_IDLE) && lk_req_valid;
    wire         lk_acked = (lk_state_ff == LK_WAIT) && (ack_lk_sync == req_tgl_ff);

    acsr_sync2 u_ack_sync (
        .clk   (link_clk),
        .rst_n (rst_n),
        .en    (1'b1),
        .d     (ack_tgl_ff),
        .q     (ack_lk_sync)
    );

    // Answer pulse is registered so it stands one full link cycle
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_state_ff     <= LK_IDLE;
            lk_hold_ff      <= '0;
            req_tgl_ff      <= 1'b0;
            lk_rsp_valid_ff <= 1'b0;
            lk_rsp_data_ff  <= BYTE_ZERO;
        end else begin
            lk_rsp_valid_ff <= lk_acked;
            case (lk_state_ff)
                LK_IDLE: begin
                    if (lk_take) begin
                        lk_hold_ff  <= lk_req;
                        req_tgl_ff  <= ~req_tgl_ff;
                        lk_state_ff <= LK_WAIT;
                    end
                end
                LK_WAIT: begin
                    if (lk_acked) begin
                        lk_rsp_data_ff <= rsp_byte_ff;
                        lk_state_ff    <= LK_DONE;
                    end
                end
                LK_DONE: begin
                    lk_state_ff <= LK_IDLE;
                end
                default: begin
                    lk_state_ff <= LK_IDLE;
                end
            endcase
        end
    end

    // Ready only while idle, so a second request waits for the answer
    assign lk_req_ready = (lk_state_ff == LK_IDLE);
    assign lk_rsp_valid = lk_rsp_valid_ff;
    assign lk_rsp_data  = lk_rsp_data_ff;

    // Core domain: request detection
    logic        req_core_sync;
    logic        req_seen_ff;

    acsr_sync2 u_req_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (ce),
        .d     (req_tgl_ff),
        .q     (req_core_sync)
    );

    // The held request is stable for as long as the toggles differ
    wire         req_evt = ce && (req_core_sync != req_seen_ff);
    wire         rd_go   = req_evt && (lk_hold_ff.op == OP_READ);
    wire         addr_go = req_evt && (lk_hold_ff.op == OP_ADDR);
    wire         stop_go = req_evt && (lk_hold_ff.op == OP_STOP);

    // Core domain: register state
    logic [6:0]          ptr_ff;
    logic [SAMPLE_W-1:0] data_ff [NUM_AXES];
    logic [1:0]          low_ff  [NUM_AXES];
    logic [2:0]          dr_ff;
    logic [2:0]          ow_ff;
    logic                all_dr_ff;
    logic                all_ow_ff;
    logic [7:0]          origin_ff;
    acsr_fn_s            fn_prev_ff;
    logic                drdy_lvl_ff;
    logic [1:0]          mode_prev_ff;

    // High byte read strobe per axis
    wire [2:0]  hi_rd;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_AXES; gi++) begin : g_hi
            assign hi_rd[gi] = rd_go && (ptr_ff == high_addr(gi));
        end
    endgenerate

    // Leaving standby clears the status and data contents
    wire        act_evt   = (mode_prev_ff == MODE_STANDBY) && (op_mode != MODE_STANDBY);
    wire [2:0]  new_smp   = smp_valid ? smp_axes : 3'b000;
    wire        any_hi_rd = |hi_rd;

    // A sample arriving with the clearing read wins over the clear
    wire [2:0]  nxt_dr     = new_smp | (dr_ff & ~hi_rd);
    // Overwrite: a sample lands on an axis whose last one is still unread
    wire [2:0]  ow_hit     = new_smp & dr_ff;
    wire [2:0]  nxt_ow     = ow_hit | (ow_ff & ~hi_rd);
    // Enabled axes still waiting for their high byte after this edge
    wire [2:0]  en_pending = nxt_dr & axis_en;
    wire        rest_done  = any_hi_rd && ~|en_pending;
    wire        nxt_all_dr = (|(new_smp & axis_en)) | (all_dr_ff & ~rest_done);
    wire        nxt_all_ow = (|(ow_hit & axis_en)) | (all_ow_ff & ~rest_done);

    // Origin bits: rising edge sets, source-register read clears
    wire        drdy_lvl  = (all_ow_ff | all_dr_ff) & drdy_int_en;
    // One-cycle strobes of reads at the source registers
    wire        rd_mode   = rd_go && (ptr_ff == ADDR_MODE);
    wire        rd_trans  = rd_go && (ptr_ff == ADDR_TRANSIENT);
    wire        rd_orient = rd_go && (ptr_ff == ADDR_ORIENT);
    wire        rd_pulse  = rd_go && (ptr_ff == ADDR_PULSE);
    wire        rd_motion = rd_go && (ptr_ff == ADDR_MOTION);
    wire [7:0]  org_set;
    wire [7:0]  org_clr;
    assign org_set = {rise(fn_irq.sleep, fn_prev_ff.sleep),
                      1'b0,
                      rise(fn_irq.trans, fn_prev_ff.trans),
                      rise(fn_irq.orient, fn_prev_ff.orient),
                      rise(fn_irq.pulse, fn_prev_ff.pulse),
                      rise(fn_irq.motion, fn_prev_ff.motion),
                      1'b0,
                      rise(drdy_lvl, drdy_lvl_ff)};
    // Data-ready origin clears with the combined flags, never on a status read
    assign org_clr = {rd_mode,
                      1'b0,
                      rd_trans,
                      rd_orient,
                      rd_pulse,
                      rd_motion,
                      1'b0,
                      rest_done};
    wire [7:0]  nxt_origin = org_set | (origin_ff & ~org_clr);

    // Read data selection
    wire [7:0]  status_byte = {all_ow_ff, ow_ff[AXIS_Z], ow_ff[AXIS_Y], ow_ff[AXIS_X],
                               all_dr_ff, dr_ff[AXIS_Z], dr_ff[AXIS_Y], dr_ff[AXIS_X]};
    wire [7:0]  mode_byte   = {MODE_PAD, op_mode};
    wire [7:0]  x_hi = high_byte(data_ff[AXIS_X]);
    wire [7:0]  y_hi = high_byte(data_ff[AXIS_Y]);
    wire [7:0]  z_hi = high_byte(data_ff[AXIS_Z]);
    // Low bytes come only from the latch; a lone low read sees the last latch
    wire [7:0]  x_lo = low_byte(low_ff[AXIS_X]);
    wire [7:0]  y_lo = low_byte(low_ff[AXIS_Y]);
    wire [7:0]  z_lo = low_byte(low_ff[AXIS_Z]);
    wire [7:0]  rd_byte =
        (ptr_ff == ADDR_STATUS) ? status_byte :
        (ptr_ff == ADDR_X_HIGH) ? x_hi :
        (ptr_ff == ADDR_X_LOW)  ? x_lo :
        (ptr_ff == ADDR_Y_HIGH) ? y_hi :
        (ptr_ff == ADDR_Y_LOW)  ? y_lo :
        (ptr_ff == ADDR_Z_HIGH) ? z_hi :
        (ptr_ff == ADDR_Z_LOW)  ? z_lo :
        (ptr_ff == ADDR_MODE)   ? mode_byte :
        (ptr_ff == ADDR_ORIGIN) ? origin_ff : BYTE_ZERO;

    // A stop parks the pointer on the status byte, ending the burst
    wire [6:0]  nxt_ptr = stop_go ? ADDR_RESET :
                          addr_go ? lk_hold_ff.addr :
                          rd_go   ? next_addr(ptr_ff, fast_read) : ptr_ff;

    // Handshake and pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_seen_ff <= 1'b0;
            ack_tgl_ff  <= 1'b0;
            rsp_byte_ff <= BYTE_ZERO;
            ptr_ff      <= ADDR_RESET;
        end else if (ce) begin
            ptr_ff <= nxt_ptr;
            if (req_evt) begin
                req_seen_ff <= req_core_sync;
                ack_tgl_ff  <= req_core_sync;
                rsp_byte_ff <= rd_go ? rd_byte : BYTE_ZERO;
            end
        end
    end

    // Status flags, origin bits and edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dr_ff        <= 3'b000;
            ow_ff        <= 3'b000;
            all_dr_ff    <= 1'b0;
            all_ow_ff    <= 1'b0;
            origin_ff    <= ORIGIN_RST;
            fn_prev_ff   <= '0;
            drdy_lvl_ff  <= 1'b0;
            mode_prev_ff <= MODE_STANDBY;
        end else if (ce) begin
            fn_prev_ff   <= fn_irq;
            drdy_lvl_ff  <= drdy_lvl;
            mode_prev_ff <= op_mode;
            if (act_evt) begin
                dr_ff     <= 3'b000;
                ow_ff     <= 3'b000;
                all_dr_ff <= 1'b0;
                all_ow_ff <= 1'b0;
                origin_ff <= ORIGIN_RST;
            end else begin
                dr_ff     <= nxt_dr;
                ow_ff     <= nxt_ow;
                all_dr_ff <= nxt_all_dr;
                all_ow_ff <= nxt_all_ow;
                origin_ff <= nxt_origin;
            end
        end
    end

    // Sample storage and low byte latches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                data_ff[i] <= '0;
                low_ff[i]  <= 2'b00;
            end
        end else if (ce) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                if (act_evt) begin
                    data_ff[i] <= '0;
                    low_ff[i]  <= 2'b00;
                end else begin
                    if (new_smp[i]) begin
                        data_ff[i] <= smp.axis[i];
                    end
                    // Old sample latched even if a new one lands now
                    if (hi_rd[i]) begin
                        low_ff[i] <= data_ff[i][1:0];
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: verification/acsr_checker.sv */
// Link port protocol checker for the sample status register group
`timescale 1ns/1ns
`default_nettype none
module acsr_checker
    import acsr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       link_clk,
    input  wire logic       lk_req_valid,
    input  wire acsr_req_s  lk_req,
    input  wire logic       lk_req_ready,
    input  wire logic       lk_rsp_valid,
    input  wire logic [7:0] lk_rsp_data
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rst_n);
    wire  take = lk_req_valid && lk_req_ready;
    logic rd_ff;
    // Remembers whether the pending answer belongs to a read
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) rd_ff <= 1'b0;
        else if (take) rd_ff <= (lk_req.op == OP_READ);
    end
    chk_take_busy: assert property (take |=> !lk_req_ready)
        else $error("ready stayed high after a request was taken");
    chk_rsp_bound: assert property (take |-> ##[3:20] lk_rsp_valid)
        else $error("no answer within bound");
    chk_rsp_pulse: assert property (lk_rsp_valid |=> !lk_rsp_valid)
        else $error("answer pulse longer than one cycle");
    chk_ready_back: assert property (lk_rsp_valid |=> lk_req_ready)
        else $error("ready not back after answer");
    chk_busy_hold: assert property (!lk_req_ready && !lk_rsp_valid |=> !lk_req_ready)
        else $error("ready returned without an answer");
    chk_rsp_busy: assert property (lk_rsp_valid |-> !lk_req_ready)
        else $error("answer while idle");
    chk_data_hold: assert property (!lk_rsp_valid |-> $stable(lk_rsp_data))
        else $error("answer data moved between answers");
    chk_ctrl_zero: assert property (lk_rsp_valid && !rd_ff |-> lk_rsp_data == 8'h00)
        else $error("address or stop answer not zero");
    cov_read: cover property (take && lk_req.op == OP_READ);
    cov_stop: cover property (take && lk_req.op == OP_STOP);
    cov_rsp:  cover property (lk_rsp_valid && rd_ff && lk_rsp_data != 8'h00);
endmodule
bind acsr_core acsr_checker u_chk (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .lk_req_valid(lk_req_valid),
    .lk_req(lk_req), .lk_req_ready(lk_req_ready), .lk_rsp_valid(lk_rsp_valid), .lk_rsp_data(lk_rsp_data));
`default_nettype wire

/* File: verification/acsr_host_model.sv */
// Host model issuing link requests to the register group
`timescale 1ns/1ns
`default_nettype none
module acsr_host_model
    import acsr_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       rst_n,
    input  wire logic       lk_req_ready,
    input  wire logic       lk_rsp_valid,
    input  wire logic [7:0] lk_rsp_data,
    output var  logic       lk_req_valid,
    output var  acsr_req_s  lk_req
);
    initial begin
        lk_req_valid = 1'b0;
        lk_req = '0;
    end
    task automatic xfer(input acsr_op_e k, input logic [6:0] a, output logic [7:0] d, output bit ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(posedge link_clk);
        #5;
        lk_req_valid = 1'b1;
        lk_req = acsr_req_s'({k, a});
        for (n = 0; n < 40 && lk_req_ready !== 1'b1; n++) @(negedge link_clk);
        @(posedge link_clk);
        #5;
        lk_req_valid = 1'b0;
        // Idle lines inverted so stale fields are never read as live
        lk_req = acsr_req_s'(~lk_req);
        for (n = 0; n < 40; n++) begin
            @(negedge link_clk);
            if (lk_rsp_valid === 1'b1) begin
                d = lk_rsp_data;
                ok = 1'b1;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: verification/accel_sample_status_regs_tb.sv */
// Self-checking bench for the sample status register group
`timescale 1ns/1ns
`default_nettype none
module accel_sample_status_regs_tb;
    import acsr_pkg::*;
    logic         clk = 1'b0;
    logic         link_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         ce = 1'b1;
    logic         smp_valid = 1'b0;
    acsr_sample_s smp = '0;
    logic [2:0]   smp_axes = 3'h0;
    logic [2:0]   axis_en = 3'h7;
    logic [1:0]   op_mode = 2'h0;
    logic         fast_read = 1'b0;
    logic         drdy_int_en = 1'b1;
    acsr_fn_s     fn_irq = '0;
    logic         lk_req_valid;
    logic         lk_req_ready;
    logic         lk_rsp_valid;
    acsr_req_s    lk_req;
    logic [7:0]   lk_rsp_data;
    logic [7:0]   d;
    logic [7:0]   exp_q [$];
    logic [7:0]   org_bit [5] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04};
    logic [6:0]   src_adr [5] = '{ADDR_MODE, ADDR_TRANSIENT, ADDR_ORIENT, ADDR_PULSE, ADDR_MOTION};
    logic [1:0]   modes [3] = '{2'h2, 2'h0, 2'h1};
    int           err_total = 0;
    int           comparisons = 0;
    always #25 clk = ~clk;
    always #16 link_clk = ~link_clk;
    acsr_core u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .smp_valid(smp_valid), .smp(smp), .smp_axes(smp_axes),
        .axis_en(axis_en), .op_mode(op_mode), .fast_read(fast_read), .drdy_int_en(drdy_int_en), .fn_irq(fn_irq),
        .link_clk(link_clk), .lk_req_valid(lk_req_valid), .lk_req(lk_req), .lk_req_ready(lk_req_ready),
        .lk_rsp_valid(lk_rsp_valid), .lk_rsp_data(lk_rsp_data));
    acsr_host_model u_host (.link_clk(link_clk), .rst_n(rst_n), .lk_req_ready(lk_req_ready),
        .lk_rsp_valid(lk_rsp_valid), .lk_rsp_data(lk_rsp_data), .lk_req_valid(lk_req_valid), .lk_req(lk_req));
    function automatic logic [7:0] hi(input logic [9:0] v);
        return v[9:2];
    endfunction
    function automatic logic [7:0] lo(input logic [9:0] v);
        return {v[1:0], 6'h00};
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic req(input acsr_op_e k, input logic [6:0] a, output logic [7:0] r);
        bit ok;
        u_host.xfer(k, a, r, ok);
        if (!ok) begin
            err_total++;
            $display("wrong value link answer expected 1 seen 0");
            complete_run();
        end
    endtask
    // Burst from a, one read per queued expectation, then stop
    task automatic burst(input string what, input logic [6:0] a);
        logic [7:0] r;
        req(OP_ADDR, a, r);
        while (exp_q.size() > 0) begin
            req(OP_READ, a, r);
            check(what, exp_q.pop_front(), r);
        end
        req(OP_STOP, ADDR_RESET, r);
    endtask
    task automatic sample(input logic [9:0] x, input logic [9:0] y, input logic [9:0] z, input logic [2:0] ax);
        @(posedge clk);
        #5;
        smp_valid = 1'b1;
        smp = acsr_sample_s'({z, y, x});
        smp_axes = ax;
        @(posedge clk);
        #5;
        smp_valid = 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #5 rst_n = 1'b1;
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        burst("reset image", ADDR_STATUS);
        exp_q = '{8'h00, 8'h00};
        burst("reset mode origin", ADDR_MODE);
        $display("test reset done");
        @(posedge clk);
        #5 op_mode = 2'h1;
        sample(10'h2a5, 10'h155, 10'h3ff, 3'h7);
        exp_q = '{8'h0f};
        burst("new status", ADDR_STATUS);
        exp_q = '{8'h01, 8'h01};
        burst("mode origin", ADDR_MODE);
        exp_q = '{8'h0f, hi(10'h2a5), lo(10'h2a5), hi(10'h155), lo(10'h155), hi(10'h3ff), lo(10'h3ff)};
        burst("seven byte burst", ADDR_STATUS);
        exp_q = '{8'h00};
        burst("status read out", ADDR_STATUS);
        exp_q = '{8'h00};
        burst("origin read out", ADDR_ORIGIN);
        $display("test burst done");
        sample(10'h101, 10'h000, 10'h000, 3'h1);
        sample(10'h2c3, 10'h000, 10'h000, 3'h1);
        exp_q = '{8'h99};
        burst("overwrite status", ADDR_STATUS);
        req(OP_ADDR, ADDR_X_HIGH, d);
        req(OP_READ, ADDR_X_HIGH, d);
        check("x high", hi(10'h2c3), d);
        sample(10'h0ff, 10'h000, 10'h000, 3'h1);
        req(OP_READ, ADDR_X_LOW, d);
        check("x low", lo(10'h2c3), d);
        req(OP_STOP, ADDR_RESET, d);
        exp_q = '{8'h09};
        burst("status after high", ADDR_STATUS);
        $display("test overwrite done");
        @(posedge clk);
        #5;
        fast_read = 1'b1;
        axis_en = 3'h1;
        sample(10'h3c0, 10'h040, 10'h200, 3'h7);
        exp_q = '{8'h9f, 8'hf0, 8'h10, 8'h80};
        burst("fast burst", ADDR_STATUS);
        sample(10'h004, 10'h008, 10'h000, 3'h3);
        exp_q = '{8'h01};
        burst("x high only", ADDR_X_HIGH);
        exp_q = '{8'h02};
        burst("partial enable", ADDR_STATUS);
        @(posedge clk);
        #5;
        fast_read = 1'b0;
        axis_en = 3'h7;
        $display("test fast read done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            #5 fn_irq = acsr_fn_s'(5'h10 >> i);
            repeat (3) @(posedge clk);
            exp_q = '{org_bit[i]};
            burst("origin set", ADDR_ORIGIN);
            exp_q = '{(i == 0) ? 8'h01 : 8'h00};
            burst("source read", src_adr[i]);
            exp_q = '{8'h00};
            burst("origin cleared", ADDR_ORIGIN);
        end
        @(posedge clk);
        #5 fn_irq = '0;
        $display("test origin done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            #5 op_mode = modes[i];
            // Standby keeps the data-ready origin; entering wake wipes it
            exp_q = '{{6'h00, modes[i]}, (i == 1) ? 8'h01 : 8'h00};
            burst("mode field", ADDR_MODE);
            if (i == 0) sample(10'h1ff, 10'h1ff, 10'h1ff, 3'h7);
        end
        exp_q = '{8'h00, 8'h00};
        burst("standby to active", ADDR_STATUS);
        exp_q = '{8'h00};
        burst("reserved", 7'h07);
        $display("test mode done");
        complete_run();
    end
endmodule
`default_nettype wire
